//--- rtl/hdc_pkg.sv
// hdc_pkg: constants, types and field layout of the hub device configuration register
// assumes: included before every design file of this block
package hdc_pkg;

    localparam logic [7:0] HDC_CFG_OFFSET   = 8'h05;
    localparam logic [7:0] HDC_CFG_RW_MASK  = 8'hFE;
    localparam logic [7:0] HDC_CFG_RESET    = 8'h00;
    localparam logic [7:0] HDC_RD_UNMAPPED  = 8'h00;
    localparam int         HDC_BIT_STRING   = 7;
    localparam int         HDC_BIT_SERIAL   = 6;
    localparam int         HDC_BIT_LP_INHIB = 5;
    localparam int         HDC_BIT_IND_LED  = 4;
    localparam int         HDC_BIT_GANGED   = 3;
    localparam int         HDC_BIT_PWR_MGMT = 2;
    localparam int         HDC_BIT_LP_TMR   = 1;
    localparam int         HDC_BIT_RSVD     = 0;

    // strap sampling then normal operation
    typedef enum logic [1:0] {
        HDC_ST_STRAP = 2'b01,
        HDC_ST_RUN   = 2'b10
    } hdc_state_t;

    // multiplexed strap terminals, sampled once at reset release
    typedef struct packed {
        logic strap_serial_data_pin;
        logic strap_indicator_addr3_pin;
        logic strap_shared_power_addr2_pin;
        logic strap_power_mgmt_addr1_pin;
    } hdc_straps_t;

    // one byte write from the eeprom loader or the smbus slave
    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
        logic [7:0] data;
    } hdc_wr_t;

endpackage

//--- rtl/hdc_lp_gate.sv
// hdc_lp_gate: gates U1/U2 entry initiation and acceptance by the inhibit bit
// assumes: one clock; power-on reset arrives on rst_n
`timescale 1ns/10ps
`default_nettype none
module hdc_lp_gate (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic link_lowpower_inhibit,
    input  wire logic forced_link_pm_accept_message_rx,
    input  wire logic forced_link_pm_accept_message_tx,
    input  wire logic upstream_disconnect,
    input  wire logic entry_req_rx,
    input  wire logic entry_want_tx,
    output logic      forced_q,
    output logic      entry_accept_q,
    output logic      entry_initiate_q
);
    import hdc_pkg::*;

    wire logic msg_seen = forced_link_pm_accept_message_rx | forced_link_pm_accept_message_tx;
    // set beats the disconnect clear in the same cycle
    wire logic forced_d = msg_seen | (forced_q & ~upstream_disconnect);   // [R7]
    wire logic allow    = ~link_lowpower_inhibit | forced_d;               // [R6]

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            forced_q         <= 1'b0;
            entry_accept_q   <= 1'b0;
            entry_initiate_q <= 1'b0;
        end else begin
            forced_q         <= forced_d;
            entry_accept_q   <= entry_req_rx & allow;    // [R6]
            entry_initiate_q <= entry_want_tx & allow;   // [R6]
        end
    end

    no_accept_inhib_a: assert property (@(posedge clock) disable iff (!rst_n) // [R6]
        link_lowpower_inhibit && !forced_q && !msg_seen
        |=> !entry_accept_q && !entry_initiate_q)
        else $error("low power entry passed while inhibited");
    forced_holds_a: assert property (@(posedge clock) disable iff (!rst_n) // [R7]
        forced_q && !upstream_disconnect |=> forced_q)
        else $error("forced accept dropped without disconnect");
    forced_sets_a: assert property (@(posedge clock) disable iff (!rst_n) // [R7]
        msg_seen ##1 (entry_req_rx && !upstream_disconnect) |=> entry_accept_q)
        else $error("entry refused after forced accept message");
endmodule
`default_nettype wire

//--- rtl/hdc_config_reg.sv
// hdc_config_reg: hub device configuration byte with strap capture and two loaders
// assumes: inputs synchronous to clock; i2c_mode steady after reset
//
// Operation
// R1: string enable in I2C mode lets eeprom content fill the string registers.
// R2: string enable in SMBus mode lets host writes to string registers through.
// R3: serial enable in I2C mode lets eeprom content fill the serial number.
// R4: serial enable in SMBus mode lets host writes to serial number through.
// R5: string and serial enables reset to zero.
// R6: inhibit bit blocks U1/U2 initiate and accept unless forced accept seen.
// R7: after forced accept message, U1/U2 stay enabled until reset or disconnect.
// R8: inhibit bit captured from serial data strap at reset release.
// R9: indicator bit captured from indicator/address-3 strap at reset release.
// R10: shared power bit captured from address-2 strap at reset release.
// R11: power management bit captured from address-1 strap at reset release.
// R12: in I2C mode eeprom bytes replace the strapped bits.
// R13: in SMBus mode host writes replace the strapped bits.
// R14: power management bit zero enables both power switching and over-current detection.
// R15: single byte at offset 05h; bit 0 reads zero and ignores writes.
`timescale 1ns/10ps
`default_nettype none
module hdc_config_reg (
    input  wire logic                clock,
    input  wire logic                rst_n,
    input  wire hdc_pkg::hdc_straps_t straps,
    input  wire logic                i2c_mode,
    input  wire hdc_pkg::hdc_wr_t    eeprom_wr,
    input  wire hdc_pkg::hdc_wr_t    smbus_wr,
    input  wire logic [7:0]          rd_addr,
    input  wire logic                string_wr_from_eeprom,
    input  wire logic                string_wr_from_smbus,
    input  wire logic                serial_wr_from_eeprom,
    input  wire logic                serial_wr_from_smbus,
    input  wire logic                self_powered,
    input  wire logic                forced_link_pm_accept_message_rx,
    input  wire logic                forced_link_pm_accept_message_tx,
    input  wire logic                upstream_disconnect,
    input  wire logic                lp_entry_req_rx,
    input  wire logic                lp_entry_want_tx,
    output logic [7:0]               rd_data,
    output logic [7:0]               device_configuration,
    output logic                     strap_done,
    output logic                     string_wr_accept,
    output logic                     serial_wr_accept,
    output logic                     port_power_switch_en,
    output logic                     overcurrent_detect_en,
    output logic                     lp_forced,
    output logic                     lp_entry_accept,
    output logic                     lp_entry_initiate
);
    import hdc_pkg::*;

    hdc_state_t state_q;
    hdc_state_t state_d;
    logic [7:0] cfg_q;
    logic [7:0] cfg_d;
    logic [7:0] rd_data_q;
    logic       str_acc_q;
    logic       ser_acc_q;
    logic       pwr_sw_q;
    logic       oc_det_q;

    function automatic logic hit(input hdc_wr_t w);
        hit = w.valid && (w.addr == HDC_CFG_OFFSET);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // register next value
    wire logic       in_run    = (state_q == HDC_ST_RUN);
    wire logic       eep_take  = in_run & i2c_mode & hit(eeprom_wr);     // [R12]
    wire logic       smb_take  = in_run & ~i2c_mode & hit(smbus_wr);     // [R13]
    wire logic [7:0] strap_val = {cfg_q[HDC_BIT_STRING], cfg_q[HDC_BIT_SERIAL],
                                  straps.strap_serial_data_pin,          // [R8]
                                  straps.strap_indicator_addr3_pin,      // [R9]
                                  straps.strap_shared_power_addr2_pin,   // [R10]
                                  straps.strap_power_mgmt_addr1_pin,     // [R11]
                                  cfg_q[HDC_BIT_LP_TMR], 1'b0};

    always_comb begin
        state_d = HDC_ST_RUN;
        cfg_d   = cfg_q;
        unique case (state_q)
            HDC_ST_STRAP: begin
                cfg_d = strap_val;
            end
            HDC_ST_RUN: begin
                if (eep_take) begin
                    cfg_d = eeprom_wr.data & HDC_CFG_RW_MASK;   // [R12] [R15]
                end else if (smb_take) begin
                    cfg_d = smbus_wr.data & HDC_CFG_RW_MASK;    // [R13] [R15]
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // side effects of the enables and the power management bit
    wire logic str_en   = cfg_q[HDC_BIT_STRING];
    wire logic ser_en   = cfg_q[HDC_BIT_SERIAL];
    wire logic str_acc  = str_en & (i2c_mode ? string_wr_from_eeprom    // [R1]
                                             : string_wr_from_smbus);   // [R2]
    wire logic ser_acc  = ser_en & (i2c_mode ? serial_wr_from_eeprom    // [R3]
                                             : serial_wr_from_smbus);   // [R4]
    wire logic pm_n     = cfg_q[HDC_BIT_PWR_MGMT];
    wire logic pwr_sw   = ~pm_n | ~self_powered;                         // [R14]
    wire logic oc_det   = ~pm_n | self_powered;                          // [R14]
    wire logic [7:0] rd_next = (rd_addr == HDC_CFG_OFFSET) ? cfg_q : HDC_RD_UNMAPPED; // [R15]

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q   <= HDC_ST_STRAP;
            cfg_q     <= HDC_CFG_RESET;   // [R5]
            rd_data_q <= HDC_RD_UNMAPPED;
            str_acc_q <= 1'b0;
            ser_acc_q <= 1'b0;
            pwr_sw_q  <= 1'b0;
            oc_det_q  <= 1'b0;
        end else begin
            state_q   <= state_d;
            cfg_q     <= cfg_d;
            rd_data_q <= rd_next;
            str_acc_q <= str_acc;
            ser_acc_q <= ser_acc;
            pwr_sw_q  <= pwr_sw;
            oc_det_q  <= oc_det;
        end
    end

    assign rd_data               = rd_data_q;
    assign device_configuration  = cfg_q;
    assign strap_done            = state_q[1];
    assign string_wr_accept      = str_acc_q;
    assign serial_wr_accept      = ser_acc_q;
    assign port_power_switch_en  = pwr_sw_q;
    assign overcurrent_detect_en = oc_det_q;

    ////////////////////////////////////////////////////////////////////////////////
    // link low power gating
    hdc_lp_gate u_lp_gate (
        .clock                            (clock),
        .rst_n                            (rst_n),
        .link_lowpower_inhibit            (cfg_q[HDC_BIT_LP_INHIB]),   // [R6]
        .forced_link_pm_accept_message_rx (forced_link_pm_accept_message_rx),
        .forced_link_pm_accept_message_tx (forced_link_pm_accept_message_tx),
        .upstream_disconnect              (upstream_disconnect),
        .entry_req_rx                     (lp_entry_req_rx),
        .entry_want_tx                    (lp_entry_want_tx),
        .forced_q                         (lp_forced),
        .entry_accept_q                   (lp_entry_accept),
        .entry_initiate_q                 (lp_entry_initiate)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    sequence strap_step_s;
        state_q == HDC_ST_STRAP ##1 state_q == HDC_ST_RUN;
    endsequence

    strap_capture_a: assert property (@(posedge clock) disable iff (!rst_n) // [R8]
        strap_step_s |-> cfg_q[5:2] == $past(straps))
        else $error("strapped bits not captured at reset release");
    enables_reset_a: assert property (@(posedge clock) disable iff (!rst_n) // [R5]
        strap_step_s |-> cfg_q[7:6] == 2'b00)
        else $error("enables not zero after reset");
    rsvd_zero_a: assert property (@(posedge clock) disable iff (!rst_n) // [R15]
        rd_addr == HDC_CFG_OFFSET
        |=> rd_data[HDC_BIT_RSVD] == 1'b0 && rd_data[7:1] == $past(cfg_q[7:1]))
        else $error("config read wrong or reserved bit set");
    eeprom_apply_a: assert property (@(posedge clock) disable iff (!rst_n) // [R12]
        eep_take |=> cfg_q == ($past(eeprom_wr.data) & HDC_CFG_RW_MASK))
        else $error("eeprom byte not applied in i2c mode");
    smbus_apply_a: assert property (@(posedge clock) disable iff (!rst_n) // [R13]
        in_run && !i2c_mode && hit(smbus_wr) |=> cfg_q == ($past(smbus_wr.data) & HDC_CFG_RW_MASK))
        else $error("smbus byte not applied in smbus mode");
    smbus_ignored_a: assert property (@(posedge clock) disable iff (!rst_n) // [R13]
        in_run && i2c_mode && !hit(eeprom_wr) |=> $stable(cfg_q))
        else $error("config changed without eeprom write in i2c mode");
    string_gate_a: assert property (@(posedge clock) disable iff (!rst_n) // [R2]
        !str_en |=> !string_wr_accept)
        else $error("string write accepted while disabled");
    serial_gate_a: assert property (@(posedge clock) disable iff (!rst_n) // [R3]
        ser_en && i2c_mode && serial_wr_from_eeprom |=> serial_wr_accept)
        else $error("serial load refused while enabled");
    full_pm_a: assert property (@(posedge clock) disable iff (!rst_n) // [R14]
        !pm_n |=> port_power_switch_en && overcurrent_detect_en)
        else $error("full power management not honoured");
    string_eeprom_a: assert property (@(posedge clock) disable iff (!rst_n) // [R1]
        str_en && i2c_mode && string_wr_from_eeprom |=> string_wr_accept)
        else $error("string load refused while enabled in i2c mode");
    string_smbus_a: assert property (@(posedge clock) disable iff (!rst_n) // [R2]
        str_en && !i2c_mode && string_wr_from_smbus |=> string_wr_accept)
        else $error("string write refused while enabled in smbus mode");
    serial_smbus_a: assert property (@(posedge clock) disable iff (!rst_n) // [R4]
        ser_en && !i2c_mode && serial_wr_from_smbus |=> serial_wr_accept)
        else $error("serial write refused while enabled in smbus mode");
    serial_off_a: assert property (@(posedge clock) disable iff (!rst_n) // [R3]
        !ser_en |=> !serial_wr_accept)
        else $error("serial write accepted while disabled");
    inhibit_strap_a: assert property (@(posedge clock) disable iff (!rst_n) // [R8]
        strap_step_s |-> cfg_q[HDC_BIT_LP_INHIB] == $past(straps.strap_serial_data_pin))
        else $error("inhibit bit not taken from serial data strap");
    indicator_strap_a: assert property (@(posedge clock) disable iff (!rst_n) // [R9]
        strap_step_s |-> cfg_q[HDC_BIT_IND_LED] == $past(straps.strap_indicator_addr3_pin))
        else $error("indicator bit not taken from its strap");
    shared_power_strap_a: assert property (@(posedge clock) disable iff (!rst_n) // [R10]
        strap_step_s |-> cfg_q[HDC_BIT_GANGED] == $past(straps.strap_shared_power_addr2_pin))
        else $error("shared power bit not taken from its strap");
    power_mgmt_strap_a: assert property (@(posedge clock) disable iff (!rst_n) // [R11]
        strap_step_s |-> cfg_q[HDC_BIT_PWR_MGMT] == $past(straps.strap_power_mgmt_addr1_pin))
        else $error("power management bit not taken from its strap");
    wrong_source_a: assert property (@(posedge clock) disable iff (!rst_n) // [R13]
        in_run && !i2c_mode && hit(eeprom_wr) && !hit(smbus_wr) |=> $stable(cfg_q))
        else $error("config changed by eeprom write in smbus mode");
    bus_powered_pm_a: assert property (@(posedge clock) disable iff (!rst_n) // [R14]
        pm_n && !self_powered |=> port_power_switch_en && !overcurrent_detect_en)
        else $error("bus powered reduced power management wrong");
    self_powered_pm_a: assert property (@(posedge clock) disable iff (!rst_n) // [R14]
        pm_n && self_powered |=> !port_power_switch_en && overcurrent_detect_en)
        else $error("self powered reduced power management wrong");
    rd_unmapped_a: assert property (@(posedge clock) disable iff (!rst_n) // [R15]
        rd_addr != HDC_CFG_OFFSET |=> rd_data == HDC_RD_UNMAPPED)
        else $error("unmapped read not zero");
endmodule
`default_nettype wire

//--- testbench/hdc_loader_model.sv
// hdc_loader_model: eeprom loader and smbus host, each writing single bytes
// assumes: put is called by the bench; changes land on falling clock edges
`timescale 1ns/10ps
`default_nettype none
module hdc_loader_model (
    input  wire logic        clock,
    output hdc_pkg::hdc_wr_t eeprom_wr,
    output hdc_pkg::hdc_wr_t smbus_wr
);
    import hdc_pkg::*;
    initial begin
        eeprom_wr = '0;
        smbus_wr  = '0;
    end
    // one-cycle byte write; src high = eeprom loader, low = smbus host
    task automatic put(input logic src, input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        if (src) eeprom_wr = {1'b1, a, d};
        else smbus_wr = {1'b1, a, d};
        @(negedge clock);
        eeprom_wr = '0;
        smbus_wr  = '0;
    endtask
endmodule
`default_nettype wire

//--- testbench/tb_hub_device_config_register.sv
// tb_hub_device_config_register: directed checks of the configuration byte
// assumes: hdc_pkg compiled first; inputs change on falling clock edges
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_hub_device_config_register;
    import hdc_pkg::*;
    logic clock = 0, rst_n = 0, i2c_mode = 0, self_powered = 0;
    logic [3:0] straps = '0, att = '0;
    logic [4:0] lp = '0;
    logic [7:0] rd_addr = '0, rd_data, cfg;
    logic strap_done, str_acc, ser_acc, sw_en, oc_en, forced, acc, init;
    hdc_wr_t eeprom_wr, smbus_wr;
    int miscompares = 0, checks_done = 0;
    always #20 clock = ~clock;
    hdc_loader_model u_hdc_loader_model (.clock(clock), .eeprom_wr(eeprom_wr),
        .smbus_wr(smbus_wr));
    hdc_config_reg u_hdc_config_reg (.clock(clock), .rst_n(rst_n), .straps(straps),
        .i2c_mode(i2c_mode), .eeprom_wr(eeprom_wr), .smbus_wr(smbus_wr),
        .rd_addr(rd_addr), .string_wr_from_eeprom(att[3]), .string_wr_from_smbus(att[2]),
        .serial_wr_from_eeprom(att[1]), .serial_wr_from_smbus(att[0]),
        .self_powered(self_powered), .forced_link_pm_accept_message_rx(lp[4]),
        .forced_link_pm_accept_message_tx(lp[3]),
        .upstream_disconnect(lp[2]), .lp_entry_req_rx(lp[1]), .lp_entry_want_tx(lp[0]),
        .rd_data(rd_data), .device_configuration(cfg), .strap_done(strap_done),
        .string_wr_accept(str_acc), .serial_wr_accept(ser_acc),
        .port_power_switch_en(sw_en), .overcurrent_detect_en(oc_en),
        .lp_forced(forced), .lp_entry_accept(acc), .lp_entry_initiate(init));
    task automatic finish_test();
        $display("miscompares %0d checks_done %0d", miscompares, checks_done);
        if (miscompares == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic rst(input logic [3:0] s, input logic m);
        int n;
        @(negedge clock);
        rst_n = 0;
        straps = s;
        i2c_mode = m;
        repeat (12) @(negedge clock);
        `CHK("cfg in reset", 8'h00, cfg)
        rst_n = 1;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (strap_done !== 1'b1 && n < 4);
        if (strap_done !== 1'b1) begin
            miscompares++;
            finish_test();
        end
    endtask
    task automatic wr(input logic s, input logic [7:0] a, d, e);
        u_hdc_loader_model.put(s, a, d);
        `CHK("cfg", e, cfg)
    endtask
    task automatic gate(input logic [3:0] v, input logic es, ee);
        @(negedge clock);
        att = v;
        @(negedge clock);
        att = '0;
        `CHK("string accept", es, str_acc)
        `CHK("serial accept", ee, ser_acc)
    endtask
    task automatic lpq(input logic [4:0] v, input logic ea, ei);
        @(negedge clock);
        lp = v;
        @(negedge clock);
        lp = '0;
        `CHK("lp accept", ea, acc)
        `CHK("lp initiate", ei, init)
    endtask
    task automatic pwr(input logic sp, esw, eoc);
        self_powered = sp;
        repeat (2) @(negedge clock);
        `CHK("power switch", esw, sw_en)
        `CHK("overcurrent", eoc, oc_en)
    endtask
    task automatic rd(input logic [7:0] a, e);
        rd_addr = a;
        @(negedge clock);
        `CHK("rd_data", e, rd_data)
    endtask
    initial begin
        // smbus mode, straps serial data and shared power high
        rst(4'b1010, 1'b0);
        `CHK("strap cfg", 8'h28, cfg)
        pwr(1'b1, 1'b1, 1'b1);
        pwr(1'b0, 1'b1, 1'b1);
        wr(1'b0, 8'h05, 8'hFF, 8'hFE);
        wr(1'b1, 8'h05, 8'h00, 8'hFE);
        wr(1'b0, 8'h06, 8'h00, 8'hFE);
        rd(8'h05, 8'hFE);
        rd(8'h06, 8'h00);
        pwr(1'b1, 1'b0, 1'b1);
        pwr(1'b0, 1'b1, 1'b0);
        gate(4'b0101, 1'b1, 1'b1);
        gate(4'b1010, 1'b0, 1'b0);
        lpq(5'b00011, 1'b0, 1'b0);
        lpq(5'b10011, 1'b1, 1'b1);
        `CHK("lp forced", 1'b1, forced)
        lpq(5'b00011, 1'b1, 1'b1);
        lpq(5'b00100, 1'b0, 1'b0);
        lpq(5'b00011, 1'b0, 1'b0);
        lpq(5'b01001, 1'b0, 1'b1);
        wr(1'b0, 8'h05, 8'h3C, 8'h3C);
        gate(4'b0101, 1'b0, 1'b0);
        // second power-on in eeprom mode, other straps high
        rst(4'b0101, 1'b1);
        `CHK("strap cfg", 8'h14, cfg)
        `CHK("lp forced", 1'b0, forced)
        lpq(5'b00011, 1'b1, 1'b1);
        wr(1'b1, 8'h05, 8'hC3, 8'hC2);
        wr(1'b0, 8'h05, 8'h00, 8'hC2);
        rd(8'h05, 8'hC2);
        gate(4'b1010, 1'b1, 1'b1);
        gate(4'b0101, 1'b0, 1'b0);
        finish_test();
    end
endmodule
`default_nettype wire
